// ### hw/otd_pkg.sv
// constants for the opcode tail decoder
package otd_pkg;
    // instruction classes
    typedef enum logic [4:0] {
        OTD_NONE = 5'h00,
        OTD_RET_COND = 5'h01,
        OTD_ROT_RIGHT = 5'h02,
        OTD_RESTART = 5'h03,
        OTD_SUB_BORROW = 5'h04,
        OTD_SUB = 5'h05,
        OTD_STORE_PAIR = 5'h06,
        OTD_PAIR_TO_SP = 5'h07,
        OTD_STORE_ACC = 5'h08,
        OTD_STORE_IND = 5'h09,
        OTD_CARRY_SET = 5'h0A,
        OTD_SWAP_PAIRS = 5'h0B,
        OTD_XOR = 5'h0C,
        OTD_SWAP_STACK = 5'h0D,
        OTD_CALL_COND = 5'h0E
    } otd_class_e;

    // sequencer states
    typedef enum logic [2:0] {
        OTD_IDLE = 3'b001,
        OTD_RUN = 3'b010,
        OTD_ACK = 3'b100
    } otd_state_e;

    // flag vector positions
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_ZERO = 1;
    localparam int FLAG_SIGN = 2;
    localparam int FLAG_PARITY = 3;
    localparam int FLAG_AUX = 4;
    localparam logic [4:0] FLAGS_ALL = 5'h1F;
    localparam logic [4:0] FLAGS_CARRY = 5'h01;
    localparam logic [4:0] FLAGS_NONE = 5'h00;

    // cycle counts
    localparam logic [4:0] CYC_4 = 5'h04;
    localparam logic [4:0] CYC_5 = 5'h05;
    localparam logic [4:0] CYC_7 = 5'h07;
    localparam logic [4:0] CYC_11 = 5'h0B;
    localparam logic [4:0] CYC_13 = 5'h0D;
    localparam logic [4:0] CYC_16 = 5'h10;
    localparam logic [4:0] CYC_17 = 5'h11;
    localparam logic [4:0] CYC_18 = 5'h12;

    // opcodes
    localparam logic [7:0] OP_RET_EVEN = 8'hE8;
    localparam logic [7:0] OP_RET_ODD = 8'hE0;
    localparam logic [7:0] OP_RET_ZERO = 8'hC8;
    localparam logic [7:0] OP_ROT_RIGHT = 8'h0F;
    localparam logic [7:0] OP_SUB_BORROW_MEM = 8'h9E;
    localparam logic [7:0] OP_SUB_BORROW_IMM = 8'hDE;
    localparam logic [7:0] OP_SUB_MEM = 8'h96;
    localparam logic [7:0] OP_SUB_IMM = 8'hD6;
    localparam logic [7:0] OP_STORE_PAIR = 8'h22;
    localparam logic [7:0] OP_PAIR_TO_SP = 8'hF9;
    localparam logic [7:0] OP_STORE_ACC = 8'h32;
    localparam logic [7:0] OP_STORE_IND_BC = 8'h02;
    localparam logic [7:0] OP_STORE_IND_DE = 8'h12;
    localparam logic [7:0] OP_CARRY_SET = 8'h37;
    localparam logic [7:0] OP_SWAP_PAIRS = 8'hEB;
    localparam logic [7:0] OP_XOR_MEM = 8'hAE;
    localparam logic [7:0] OP_XOR_IMM = 8'hEE;
    localparam logic [7:0] OP_SWAP_STACK = 8'hE3;
    localparam logic [4:0] HI_SUB = 5'h12;
    localparam logic [4:0] HI_SUB_BORROW = 5'h13;
    localparam logic [4:0] HI_XOR = 5'h15;
    localparam logic [2:0] LO_MEM = 3'h6;
    localparam logic [1:0] HI_RESTART = 2'h3;
    localparam logic [2:0] LO_RESTART = 3'h7;
    localparam logic [1:0] HI_CALL = 2'h3;
    localparam logic [2:0] LO_CALL = 3'h4;
    // condition codes in opcode bits 5:3
    localparam logic [2:0] CC_NZ = 3'h0;
    localparam logic [2:0] CC_Z = 3'h1;
    localparam logic [2:0] CC_NC = 3'h2;
    localparam logic [2:0] CC_C = 3'h3;
    localparam logic [2:0] CC_PO = 3'h4;
    localparam logic [2:0] CC_PE = 3'h5;
    localparam logic [2:0] CC_P = 3'h6;
    localparam logic [2:0] CC_M = 3'h7;
endpackage : otd_pkg

// ### hw/otd_op_table.sv
// combinational opcode table: class, length, cycles, flag mask
`timescale 1ns/1ns
`default_nettype none
module otd_op_table (
    input wire logic [7:0] opcode,
    input wire logic cond_true,
    output otd_pkg::otd_class_e op_class,
    output logic [1:0] op_bytes,
    output logic [4:0] op_cycles,
    output logic [4:0] op_flags,
    output logic [15:0] op_target
);
    always_comb begin
        op_class = otd_pkg::OTD_NONE;
        op_bytes = 2'h0;
        op_cycles = 5'h00;
        op_flags = otd_pkg::FLAGS_NONE;
        op_target = 16'h0000;
        if (opcode == otd_pkg::OP_RET_EVEN || opcode == otd_pkg::OP_RET_ODD
            || opcode == otd_pkg::OP_RET_ZERO) begin
            op_class = otd_pkg::OTD_RET_COND;
            op_bytes = 2'h1;
            op_cycles = cond_true ? otd_pkg::CYC_11 : otd_pkg::CYC_5;
        end else if (opcode == otd_pkg::OP_ROT_RIGHT) begin
            op_class = otd_pkg::OTD_ROT_RIGHT;
            op_bytes = 2'h1;
            op_cycles = otd_pkg::CYC_4;
            op_flags = otd_pkg::FLAGS_CARRY;
        end else if (opcode[7:6] == otd_pkg::HI_RESTART
                     && opcode[2:0] == otd_pkg::LO_RESTART) begin
            op_class = otd_pkg::OTD_RESTART;
            op_bytes = 2'h1;
            op_cycles = otd_pkg::CYC_11;
            op_target = {10'h000, opcode[5:3], 3'h0};
        end else if (opcode[7:3] == otd_pkg::HI_SUB_BORROW
                     || opcode == otd_pkg::OP_SUB_BORROW_IMM) begin
            op_class = otd_pkg::OTD_SUB_BORROW;
            op_bytes = (opcode == otd_pkg::OP_SUB_BORROW_IMM) ? 2'h2 : 2'h1;
            op_cycles = (opcode[2:0] == otd_pkg::LO_MEM)
                ? otd_pkg::CYC_7 : otd_pkg::CYC_4;
            op_flags = otd_pkg::FLAGS_ALL;
        end else if (opcode[7:3] == otd_pkg::HI_SUB
                     || opcode == otd_pkg::OP_SUB_IMM) begin
            op_class = otd_pkg::OTD_SUB;
            op_bytes = (opcode == otd_pkg::OP_SUB_IMM) ? 2'h2 : 2'h1;
            op_cycles = (opcode[2:0] == otd_pkg::LO_MEM)
                ? otd_pkg::CYC_7 : otd_pkg::CYC_4;
            op_flags = otd_pkg::FLAGS_ALL;
        end else if (opcode[7:3] == otd_pkg::HI_XOR
                     || opcode == otd_pkg::OP_XOR_IMM) begin
            op_class = otd_pkg::OTD_XOR;
            op_bytes = (opcode == otd_pkg::OP_XOR_IMM) ? 2'h2 : 2'h1;
            op_cycles = (opcode[2:0] == otd_pkg::LO_MEM)
                ? otd_pkg::CYC_7 : otd_pkg::CYC_4;
            op_flags = otd_pkg::FLAGS_ALL;
        end else if (opcode == otd_pkg::OP_STORE_PAIR) begin
            op_class = otd_pkg::OTD_STORE_PAIR;
            op_bytes = 2'h3;
            op_cycles = otd_pkg::CYC_16;
        end else if (opcode == otd_pkg::OP_PAIR_TO_SP) begin
            op_class = otd_pkg::OTD_PAIR_TO_SP;
            op_bytes = 2'h1;
            op_cycles = otd_pkg::CYC_5;
        end else if (opcode == otd_pkg::OP_STORE_ACC) begin
            op_class = otd_pkg::OTD_STORE_ACC;
            op_bytes = 2'h3;
            op_cycles = otd_pkg::CYC_13;
        end else if (opcode == otd_pkg::OP_STORE_IND_BC
                     || opcode == otd_pkg::OP_STORE_IND_DE) begin
            op_class = otd_pkg::OTD_STORE_IND;
            op_bytes = 2'h1;
            op_cycles = otd_pkg::CYC_7;
        end else if (opcode == otd_pkg::OP_CARRY_SET) begin
            op_class = otd_pkg::OTD_CARRY_SET;
            op_bytes = 2'h1;
            op_cycles = otd_pkg::CYC_4;
            op_flags = otd_pkg::FLAGS_CARRY;
        end else if (opcode == otd_pkg::OP_SWAP_PAIRS) begin
            op_class = otd_pkg::OTD_SWAP_PAIRS;
            op_bytes = 2'h1;
            op_cycles = otd_pkg::CYC_4;
        end else if (opcode == otd_pkg::OP_SWAP_STACK) begin
            op_class = otd_pkg::OTD_SWAP_STACK;
            op_bytes = 2'h1;
            op_cycles = otd_pkg::CYC_18;
        end else if (opcode[7:6] == otd_pkg::HI_CALL
                     && opcode[2:0] == otd_pkg::LO_CALL) begin
            op_class = otd_pkg::OTD_CALL_COND;
            op_bytes = 2'h3;
            op_cycles = cond_true ? otd_pkg::CYC_17 : otd_pkg::CYC_11;
        end
    end
endmodule : otd_op_table
`default_nettype wire

// ### hw/otd_decode_tail.sv
// opcode tail decoder with cycle sequencer and interrupt acknowledge
// Behaviour
// - conditional returns E8, E0, C8 take 5 cycles, or 11 when taken.
// - opcode 0F rotates accumulator right in 4 cycles, carry only.
// - restart opcodes C7..FF jump to 0000..0038 in 11 cycles.
// - subtract with borrow 98-9F, 4 cycles, memory form 9E 7 cycles.
// - immediate subtract with borrow DE, two bytes, 7 cycles.
// - opcode 22 stores H-L at direct address, three bytes, 16 cycles.
// - opcode 32 stores accumulator at direct address, 13 cycles.
// - opcodes 02 and 12 store accumulator via B-C or D-E, 7 cycles.
// - opcode 37 sets carry in 4 cycles, other flags kept.
// - subtract 90-97 4 cycles, 96 memory 7, immediate D6 7 cycles.
// - opcode EB swaps H-L with D-E in 4 cycles.
// - xor A8-AF 4 cycles, AE memory 7, immediate EE 7 cycles.
// - opcode E3 swaps H-L with stack top in 18 cycles.
// - full-flag ops touch all five flags; carry-only ops just carry.
// - conditional calls take 11 cycles, or 17 when taken.
// - accepted interrupt raises acknowledge one cycle after the next cycle sync point.
`timescale 1ns/1ns
`default_nettype none
module otd_decode_tail (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic op_valid,
    input wire logic [7:0] op_code,
    input wire logic [4:0] flags_in,
    input wire logic irq_request,
    input wire logic irq_enable,
    input wire logic sync_point,
    output logic busy_r,
    output logic done_r,
    output logic hit_r,
    output otd_pkg::otd_class_e class_r,
    output logic [1:0] bytes_r,
    output logic [4:0] cycles_r,
    output logic [4:0] flag_mask_r,
    output logic taken_r,
    output logic [15:0] program_counter_r,
    output logic irq_ack_status_r
);
    otd_pkg::otd_state_e state_r;
    otd_pkg::otd_class_e tab_class;
    logic [1:0] tab_bytes;
    logic [4:0] tab_cycles;
    logic [4:0] tab_flags;
    logic [15:0] tab_target;
    logic [4:0] count_r;
    logic irq_meta_r;
    logic irq_sync_r;
    logic irq_pend_r;
    logic cond_true;
    logic last_cycle;

    function automatic logic cond_eval(input logic [2:0] cc,
                                       input logic [4:0] f);
        unique case (cc)
            otd_pkg::CC_NZ: cond_eval = !f[otd_pkg::FLAG_ZERO];
            otd_pkg::CC_Z: cond_eval = f[otd_pkg::FLAG_ZERO];
            otd_pkg::CC_NC: cond_eval = !f[otd_pkg::FLAG_CARRY];
            otd_pkg::CC_C: cond_eval = f[otd_pkg::FLAG_CARRY];
            otd_pkg::CC_PO: cond_eval = !f[otd_pkg::FLAG_PARITY];
            otd_pkg::CC_PE: cond_eval = f[otd_pkg::FLAG_PARITY];
            otd_pkg::CC_P: cond_eval = !f[otd_pkg::FLAG_SIGN];
            otd_pkg::CC_M: cond_eval = f[otd_pkg::FLAG_SIGN];
        endcase
    endfunction : cond_eval

    assign cond_true = cond_eval(op_code[5:3], flags_in);
    assign last_cycle = (state_r == otd_pkg::OTD_RUN) && (count_r == 5'h01);

    otd_op_table u_table (
        .opcode(op_code),
        .cond_true(cond_true),
        .op_class(tab_class),
        .op_bytes(tab_bytes),
        .op_cycles(tab_cycles),
        .op_flags(tab_flags),
        .op_target(tab_target)
    );

    // irq pin from another domain passes two flops
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_meta_r <= 1'b0;
            irq_sync_r <= 1'b0;
        end else begin
            irq_meta_r <= irq_request;
            irq_sync_r <= irq_meta_r;
        end
    end

    // request sampled only on an instruction's last cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_pend_r <= 1'b0;
        end else if (last_cycle && irq_sync_r && irq_enable) begin
            irq_pend_r <= 1'b1;
        end else if (state_r == otd_pkg::OTD_ACK && sync_point) begin
            irq_pend_r <= 1'b0;
        end
    end

    // sequencer: idle, counting instruction cycles, acknowledge
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= otd_pkg::OTD_IDLE;
            count_r <= 5'h00;
        end else begin
            unique case (state_r)
                otd_pkg::OTD_IDLE: begin
                    if (irq_pend_r) begin
                        state_r <= otd_pkg::OTD_ACK;
                    end else if (op_valid
                                 && tab_class != otd_pkg::OTD_NONE) begin
                        state_r <= otd_pkg::OTD_RUN;
                        count_r <= tab_cycles;
                    end
                end
                otd_pkg::OTD_RUN: begin
                    count_r <= count_r - 5'h01;
                    if (count_r == 5'h01) begin
                        state_r <= otd_pkg::OTD_IDLE;
                    end
                end
                otd_pkg::OTD_ACK: begin
                    if (sync_point) begin
                        state_r <= otd_pkg::OTD_IDLE;
                    end
                end
                default: begin
                    state_r <= otd_pkg::OTD_IDLE;
                end
            endcase
        end
    end

    // acknowledge status one cycle after the sync point following acceptance
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_ack_status_r <= 1'b0;
        end else begin
            irq_ack_status_r <= (state_r == otd_pkg::OTD_ACK)
                && sync_point;
        end
    end

    // decode results latched whenever an opcode is offered in idle with no interrupt pending
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hit_r <= 1'b0;
            class_r <= otd_pkg::OTD_NONE;
            bytes_r <= 2'h0;
            cycles_r <= 5'h00;
            flag_mask_r <= 5'h00;
            taken_r <= 1'b0;
            program_counter_r <= 16'h0000;
        end else if (state_r == otd_pkg::OTD_IDLE && op_valid
                     && !irq_pend_r) begin
            hit_r <= (tab_class != otd_pkg::OTD_NONE);
            class_r <= tab_class;
            bytes_r <= tab_bytes;
            cycles_r <= tab_cycles;
            flag_mask_r <= tab_flags;
            taken_r <= cond_true;
            if (tab_class == otd_pkg::OTD_RESTART) begin
                program_counter_r <= tab_target;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            busy_r <= (state_r == otd_pkg::OTD_IDLE)
                ? (op_valid && !irq_pend_r
                   && tab_class != otd_pkg::OTD_NONE)
                : (state_r == otd_pkg::OTD_RUN && count_r != 5'h01);
            done_r <= last_cycle;
        end
    end

    a_unknown_silent: assert property (
        @(posedge clk) disable iff (sys_rst)
        (state_r == otd_pkg::OTD_IDLE && op_valid && !irq_pend_r
         && tab_class == otd_pkg::OTD_NONE) |=> !hit_r && !busy_r)
        else $error("unknown opcode raised decode output");

    a_ret_cycles: assert property (
        @(posedge clk) disable iff (sys_rst)
        (state_r == otd_pkg::OTD_IDLE && op_valid && !irq_pend_r
         && op_code == otd_pkg::OP_RET_ZERO)
        |=> cycles_r == (flags_in[otd_pkg::FLAG_ZERO]
            ? otd_pkg::CYC_11 : otd_pkg::CYC_5))
        else $error("conditional return cycle count wrong");

    a_rot_carry: assert property (
        @(posedge clk) disable iff (sys_rst)
        (state_r == otd_pkg::OTD_IDLE && op_valid && !irq_pend_r
         && op_code == otd_pkg::OP_ROT_RIGHT)
        |=> flag_mask_r == 5'h01 && cycles_r == 5'h04)
        else $error("rotate right decode wrong");

    a_restart_pc: assert property (
        @(posedge clk) disable iff (sys_rst)
        (state_r == otd_pkg::OTD_IDLE && op_valid && !irq_pend_r
         && op_code == 8'hEF) |=> program_counter_r == 16'h0028
         && cycles_r == 5'h0B)
        else $error("restart target wrong");

    a_sbb_mem: assert property (
        @(posedge clk) disable iff (sys_rst)
        (state_r == otd_pkg::OTD_IDLE && op_valid && !irq_pend_r
         && op_code == 8'h9E) |=> cycles_r == 5'h07
         && flag_mask_r == 5'h1F)
        else $error("memory subtract with borrow decode wrong");

    a_sbi_len: assert property (
        @(posedge clk) disable iff (sys_rst)
        (state_r == otd_pkg::OTD_IDLE && op_valid && !irq_pend_r
         && op_code == 8'hDE) |=> bytes_r == 2'h2 && cycles_r == 5'h07)
        else $error("immediate subtract with borrow decode wrong");

    a_store_pair_direct_len: assert property (
        @(posedge clk) disable iff (sys_rst)
        (state_r == otd_pkg::OTD_IDLE && op_valid && !irq_pend_r
         && op_code == 8'h22)
        |=> busy_r [*8] ##8 busy_r ##1 (!busy_r && done_r))
        else $error("store pair did not take 16 cycles");

    a_swap_pair_with_stack_top_done: assert property (
        @(posedge clk) disable iff (sys_rst)
        (state_r == otd_pkg::OTD_IDLE && op_valid && !irq_pend_r
         && op_code == 8'hE3) |=> ##18 done_r)
        else $error("stack swap did not end after 18 cycles");

    a_ack_sync: assert property (
        @(posedge clk) disable iff (sys_rst)
        $rose(irq_ack_status_r) |-> $past(sync_point))
        else $error("acknowledge raised away from sync point");
endmodule : otd_decode_tail
`default_nettype wire

// ### testbench/otd_irq_model.sv
// interrupt source and sync marker model facing the opcode tail decoder
`timescale 1ns/1ns
`default_nettype none
module otd_irq_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic raise,
    input wire logic ack,
    output logic irq_request,
    output logic sync_point
);
    logic [1:0] phase_r;
    logic raise_d_r;

    // one sync marker in every four cycles
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_r <= 2'h0;
            sync_point <= 1'b0;
        end else begin
            phase_r <= phase_r + 2'h1;
            sync_point <= (phase_r == 2'h3);
        end
    end

    // request held steady until acknowledged or withdrawn
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            raise_d_r <= 1'b0;
            irq_request <= 1'b0;
        end else begin
            raise_d_r <= raise;
            if (ack || !raise) begin
                irq_request <= 1'b0;
            end else if (!raise_d_r) begin
                irq_request <= 1'b1;
            end
        end
    end
endmodule : otd_irq_model
`default_nettype wire

// ### testbench/tb_cpu_opcode_decode_tail.sv
// self-checking bench for the opcode tail decoder
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module tb_cpu_opcode_decode_tail;
    logic clk, sys_rst, op_valid, irq_enable, raise, sync_q;
    logic [7:0] op_code;
    logic [4:0] flags_in;
    logic irq_request, sync_point, busy_r, done_r, hit_r, taken_r;
    logic irq_ack_status_r;
    otd_pkg::otd_class_e class_r;
    logic [1:0] bytes_r;
    logic [4:0] cycles_r, flag_mask_r;
    logic [15:0] program_counter_r;
    int errors = 0;
    int checks_done = 0;
    int cyc_cnt = 0;

    otd_decode_tail dut (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid),
        .op_code(op_code), .flags_in(flags_in), .irq_request(irq_request),
        .irq_enable(irq_enable), .sync_point(sync_point), .busy_r(busy_r),
        .done_r(done_r), .hit_r(hit_r), .class_r(class_r),
        .bytes_r(bytes_r), .cycles_r(cycles_r), .flag_mask_r(flag_mask_r),
        .taken_r(taken_r), .program_counter_r(program_counter_r),
        .irq_ack_status_r(irq_ack_status_r));
    otd_irq_model partner (.clk(clk), .sys_rst(sys_rst), .raise(raise),
        .ack(irq_ack_status_r), .irq_request(irq_request),
        .sync_point(sync_point));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        sync_q <= sync_point;
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            errors++;
            $display("[ERR] %0t run did not finish", $time);
            results();
        end
    end

    task automatic results;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    // offer one opcode, check decode, count cycles up to done
    task automatic op(input logic [7:0] code, input logic [4:0] fl,
        input otd_pkg::otd_class_e c, input logic [1:0] b,
        input logic [4:0] cyc, input logic [4:0] m);
        int n;
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= code;
        flags_in <= fl;
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
        `CHK(hit_r, 1'b1)
        `CHK(class_r, c)
        `CHK(bytes_r, b)
        `CHK(cycles_r, cyc)
        `CHK(flag_mask_r, m)
        `CHK(busy_r, 1'b1)
        n = 0;
        while (n < 40 && done_r !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(5'(n), cyc)
        `CHK(busy_r, 1'b0)
    endtask : op

    task automatic t_ret_cond;
        op(8'hE8, 5'h08, otd_pkg::OTD_RET_COND, 2'h1, 5'h0B, 5'h00);
        `CHK(taken_r, 1'b1)
        op(8'hE8, 5'h17, otd_pkg::OTD_RET_COND, 2'h1, 5'h05, 5'h00);
        `CHK(taken_r, 1'b0)
        op(8'hE0, 5'h00, otd_pkg::OTD_RET_COND, 2'h1, 5'h0B, 5'h00);
        op(8'hE0, 5'h08, otd_pkg::OTD_RET_COND, 2'h1, 5'h05, 5'h00);
        op(8'hC8, 5'h02, otd_pkg::OTD_RET_COND, 2'h1, 5'h0B, 5'h00);
        op(8'hC8, 5'h1D, otd_pkg::OTD_RET_COND, 2'h1, 5'h05, 5'h00);
    endtask : t_ret_cond

    task automatic t_call_cond;
        op(8'hC4, 5'h00, otd_pkg::OTD_CALL_COND, 2'h3, 5'h11, 5'h00);
        `CHK(taken_r, 1'b1)
        op(8'hC4, 5'h02, otd_pkg::OTD_CALL_COND, 2'h3, 5'h0B, 5'h00);
        `CHK(taken_r, 1'b0)
        op(8'hEC, 5'h08, otd_pkg::OTD_CALL_COND, 2'h3, 5'h11, 5'h00);
        op(8'hDC, 5'h01, otd_pkg::OTD_CALL_COND, 2'h3, 5'h11, 5'h00);
        `CHK(taken_r, 1'b1)
        op(8'hD4, 5'h01, otd_pkg::OTD_CALL_COND, 2'h3, 5'h0B, 5'h00);
        op(8'hF4, 5'h04, otd_pkg::OTD_CALL_COND, 2'h3, 5'h0B, 5'h00);
        `CHK(taken_r, 1'b0)
        op(8'hFC, 5'h04, otd_pkg::OTD_CALL_COND, 2'h3, 5'h11, 5'h00);
    endtask : t_call_cond

    task automatic t_restart;
        for (int i = 0; i < 8; i++) begin
            op(8'hC7 | 8'(i << 3), 5'h00, otd_pkg::OTD_RESTART, 2'h1,
                5'h0B, 5'h00);
            `CHK(program_counter_r, 16'(i * 8))
        end
    endtask : t_restart

    // register, memory and immediate forms of subtract, borrow subtract, xor
    task automatic t_alu;
        logic [7:0] base [3] = '{8'h90, 8'h98, 8'hA8};
        otd_pkg::otd_class_e cl [3] = '{otd_pkg::OTD_SUB,
            otd_pkg::OTD_SUB_BORROW, otd_pkg::OTD_XOR};
        for (int g = 0; g < 3; g++) begin
            for (int i = 0; i < 8; i++) begin
                op(base[g] + 8'(i), 5'h00, cl[g], 2'h1,
                    (i == 6) ? 5'h07 : 5'h04, 5'h1F);
            end
        end
        op(8'hD6, 5'h01, otd_pkg::OTD_SUB, 2'h2, 5'h07, 5'h1F);
        op(8'hDE, 5'h01, otd_pkg::OTD_SUB_BORROW, 2'h2, 5'h07, 5'h1F);
        op(8'hEE, 5'h00, otd_pkg::OTD_XOR, 2'h2, 5'h07, 5'h1F);
    endtask : t_alu

    task automatic t_misc;
        op(8'h0F, 5'h00, otd_pkg::OTD_ROT_RIGHT, 2'h1, 5'h04, 5'h01);
        op(8'h22, 5'h00, otd_pkg::OTD_STORE_PAIR, 2'h3, 5'h10, 5'h00);
        op(8'hF9, 5'h00, otd_pkg::OTD_PAIR_TO_SP, 2'h1, 5'h05, 5'h00);
        op(8'h32, 5'h00, otd_pkg::OTD_STORE_ACC, 2'h3, 5'h0D, 5'h00);
        op(8'h02, 5'h00, otd_pkg::OTD_STORE_IND, 2'h1, 5'h07, 5'h00);
        op(8'h12, 5'h00, otd_pkg::OTD_STORE_IND, 2'h1, 5'h07, 5'h00);
        op(8'h37, 5'h00, otd_pkg::OTD_CARRY_SET, 2'h1, 5'h04, 5'h01);
        op(8'hEB, 5'h00, otd_pkg::OTD_SWAP_PAIRS, 2'h1, 5'h04,
            5'h00);
        op(8'hE3, 5'h00, otd_pkg::OTD_SWAP_STACK, 2'h1, 5'h12,
            5'h00);
        `CHK(program_counter_r, 16'h0038)
    endtask : t_misc

    task automatic t_outside;
        logic [7:0] codes [3] = '{8'h00, 8'h3A, 8'hC9};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            op_valid <= 1'b1;
            op_code <= codes[i];
            @(posedge clk);
            op_valid <= 1'b0;
            #1;
            `CHK(hit_r, 1'b0)
            `CHK(class_r, otd_pkg::OTD_NONE)
            `CHK(bytes_r, 2'h0)
            `CHK(busy_r, 1'b0)
            `CHK(program_counter_r, 16'h0038)
        end
    endtask : t_outside

    task automatic t_irq;
        int n;
        @(posedge clk);
        raise <= 1'b1;
        op(8'hEB, 5'h00, otd_pkg::OTD_SWAP_PAIRS, 2'h1, 5'h04,
            5'h00);
        repeat (12) begin
            @(posedge clk);
            #1;
            `CHK(irq_ack_status_r, 1'b0)
        end
        @(posedge clk);
        raise <= 1'b0;
        irq_enable <= 1'b1;
        @(posedge clk);
        raise <= 1'b1;
        op(8'hEB, 5'h00, otd_pkg::OTD_SWAP_PAIRS, 2'h1, 5'h04,
            5'h00);
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= 8'h37;
        n = 0;
        while (n < 20 && irq_ack_status_r !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
            `CHK(busy_r, 1'b0)
        end
        `CHK(irq_ack_status_r, 1'b1)
        `CHK(sync_q, 1'b1)
        @(posedge clk);
        op_valid <= 1'b0;
        raise <= 1'b0;
        #1;
        `CHK(irq_ack_status_r, 1'b0)
        n = 0;
        while (n < 20 && done_r !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(done_r, 1'b1)
    endtask : t_irq

    initial begin
        sys_rst = 1'b1;
        op_valid = 1'b0;
        op_code = 8'h00;
        flags_in = 5'h00;
        irq_enable = 1'b0;
        raise = 1'b0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        `CHK(busy_r, 1'b0)
        `CHK(irq_ack_status_r, 1'b0)
        `CHK(program_counter_r, 16'h0000)
        t_ret_cond();
        t_call_cond();
        t_restart();
        t_alu();
        t_misc();
        t_outside();
        t_irq();
        results();
    end
endmodule : tb_cpu_opcode_decode_tail
`default_nettype wire
